// ==== lm_cfg.svh ====
// Purpose: constants for the line maintenance pattern and loopback block
// Assumes: 32-bit classic Wishbone register access, one word per register
// Notes: every offset, control and status field position and detection count of the block lives here
//
// How it works
// - alarm detect runs only with recovery enabled
// - E1 criteria select: 0 first, 1 second
// - E1 first criteria: two blocks declare and clear
// - E1 second criteria: one good block clears
// - T1 8192-bit block, 9 zeros threshold
// - pattern timing from transmit or master clock
// - select 00, clock 0 gives normal data
// - select 01 sends continuous ones
// - select 00, clock 1 sends continuous zeros
// - select 10 sends pseudo-random sequence
// - 2^20-1 with zero limit T1, 2^15-1 E1
// - invert bit flips the pseudo-random sequence
// - sync: at most 6 errors per 64 bits
// - edge select: rising only or every change
// - interrupt only when flag and mask set
// - error select 00 counts pattern errors, 16 bits
// - analog loop feeds transmit to receive outputs
// - digital loop feeds transmit to receive outputs
// - patterns replace transmit data during loopback
// - pattern pins pick normal, ones, pseudo-random, loopback code
// - select 11 repeats the loopback code
`ifndef LM_CFG_SVH
`define LM_CFG_SVH

// register byte offsets
`define LM_ADDR_CTL_ZERO 8'h00
`define LM_ADDR_CTL_ONE 8'h04
`define LM_ADDR_ERR_SEL 8'h08
`define LM_ADDR_STATUS 8'h0C
`define LM_ADDR_EVENT 8'h10
`define LM_ADDR_EDGE 8'h14
`define LM_ADDR_MASK 8'h18
`define LM_ADDR_ERRCNT 8'h1C
`define LM_ADDR_CODE 8'h20

// control zero fields
`define LM_F_LOSS_CRIT 0
`define LM_F_PCLK_SEL 1
`define LM_F_PSEL_LO 2
`define LM_F_PSEL_HI 3
`define LM_F_INVERT 4
`define LM_F_T1_MODE 5
`define LM_F_CDR_EN 6
// control one fields
`define LM_F_ANALOG 0
`define LM_F_DIGITAL 1
// status zero fields
`define LM_F_ALARM 0
`define LM_F_SYNC 1

// reset values
`define LM_RST_CTL_ZERO 8'h40
`define LM_RST_CODE 10'h3_01

// alarm detection: last bit index of a 512 or 8192 bit block, so it fits 13 bits
`define LM_E1_BLOCK 13'h01FF
`define LM_T1_BLOCK 13'h1FFF
`define LM_E1_ZEROS 4'h3
`define LM_T1_ZEROS 4'h9

// pattern monitor
`define LM_WIN_BITS 6'h3F
`define LM_MAX_ERRS 7'h06
`define LM_ZLIM_BITS 14

// mode encodings
`define LM_SEL_NORMAL 2'h0
`define LM_SEL_ONES 2'h1
`define LM_SEL_PRBS 2'h2
`define LM_SEL_CODE 2'h3
`define LM_LOOP_ANALOG 2'h1
`define LM_LOOP_DIGITAL 2'h2
`define LM_ERR_PATTERN 2'h0

`endif

// ==== lm_pkg.sv ====
// Purpose: types shared by the line maintenance block
// Assumes: nothing beyond the constants header
// Notes: control bits travel as one packed struct
`default_nettype none
package lm_pkg;
   // decoded control picked from registers or hardware pins
   typedef struct packed {
      logic loss_criteria_select;
      logic pattern_clock_select;
      logic [1:0] pattern_select;
      logic pattern_invert;
      logic t1_mode;
      logic cdr_enable;
      logic analog_loop_enable;
      logic digital_loop_enable;
   } lm_ctrl_t;

   // pattern detector state
   typedef enum logic {
      DET_HUNT = 1'b0,
      DET_LOCK = 1'b1
   } det_state_t;
endpackage
`default_nettype wire

// ==== line_maintenance.sv ====
// Purpose: alarm detection, test patterns, pattern monitor and loopback routing
// Assumes: all inputs synchronous to clk_i; bit clocks are sampled levels
// Notes: line coding and the jitter attenuator sit outside this block
`include "lm_cfg.svh"
`default_nettype none
module line_maintenance
   import lm_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // hardware control pins
   input wire logic hw_mode_i,
   input wire logic [1:0] loop_select_pins_i,
   input wire logic [1:0] pattern_select_pins_i,
   // system transmit side
   input wire logic transmit_clock_i,
   input wire logic master_clock_i,
   input wire logic transmit_data_i,
   // line side
   input wire logic line_receive_clock_i,
   input wire logic line_receive_data_i,
   output logic line_transmit_clock_o,
   output logic line_transmit_pair_o,
   // system receive side
   output logic receive_clock_o,
   output logic [1:0] receive_dual_rail_data_o,
   // status
   output logic alarm_indication_status_o,
   output logic pattern_sync_status_o,
   output logic interrupt_o
);

   // software registers
   logic [7:0] ctl0_q; // control zero
   logic [1:0] ctl1_q; // loop enables
   logic [1:0] err_type_q; // error type select
   logic edge_select_q; // pattern_edge_select
   logic mask_q; // pattern_interrupt_mask
   logic event_flag_q; // pattern_event_flag
   logic [15:0] err_cnt_q; // pattern error counter
   logic [9:0] code_q; // loopback code [7:0], length-5 in [9:8]
   lm_ctrl_t ctrl; // effective control

   // bus decode helpers
   logic bus_req;
   logic wr_en;
   logic rd_en;
   assign bus_req = cyc_i & stb_i & ~ack_o;
   assign wr_en = bus_req & we_i;
   assign rd_en = bus_req & ~we_i;

   // byte lane merge used by the loopback code register
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // hardware mode takes pattern and loop choice from pins, clock select 0
   always_comb begin
      ctrl.loss_criteria_select = ctl0_q[`LM_F_LOSS_CRIT];
      ctrl.pattern_clock_select = hw_mode_i ? 1'b0 : ctl0_q[`LM_F_PCLK_SEL];
      ctrl.pattern_select = hw_mode_i ? pattern_select_pins_i : ctl0_q[`LM_F_PSEL_HI:`LM_F_PSEL_LO];
      ctrl.pattern_invert = ctl0_q[`LM_F_INVERT];
      ctrl.t1_mode = ctl0_q[`LM_F_T1_MODE];
      ctrl.cdr_enable = ctl0_q[`LM_F_CDR_EN];
      // pins 01 and 10 are the controller's requests for each loop
      ctrl.analog_loop_enable = hw_mode_i ? (loop_select_pins_i == `LM_LOOP_ANALOG)
         : ctl1_q[`LM_F_ANALOG];
      ctrl.digital_loop_enable = hw_mode_i ? (loop_select_pins_i == `LM_LOOP_DIGITAL)
         : ctl1_q[`LM_F_DIGITAL];
   end

   // control register writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl0_q <= `LM_RST_CTL_ZERO;
         ctl1_q <= 2'h0;
         err_type_q <= 2'h0;
         edge_select_q <= 1'b0;
         mask_q <= 1'b0;
         code_q <= `LM_RST_CODE;
      end else if (wr_en) begin
         case (adr_i)
            `LM_ADDR_CTL_ZERO: ctl0_q <= sel_i[0] ? dat_i[7:0] : ctl0_q;
            `LM_ADDR_CTL_ONE: ctl1_q <= sel_i[0] ? dat_i[1:0] : ctl1_q;
            `LM_ADDR_ERR_SEL: err_type_q <= sel_i[0] ? dat_i[1:0] : err_type_q;
            `LM_ADDR_EDGE: edge_select_q <= sel_i[0] ? dat_i[0] : edge_select_q;
            `LM_ADDR_MASK: mask_q <= sel_i[0] ? dat_i[0] : mask_q;
            `LM_ADDR_CODE: code_q <= 10'(merge({6'h00, code_q}, dat_i, sel_i));
            default: ; // other offsets are read only or unmapped; a write to the error counter offset clears it in its own block
         endcase
      end
   end

   // read mux and single-wait-state acknowledge; unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= bus_req;
         if (rd_en) begin
            case (adr_i)
               `LM_ADDR_CTL_ZERO: dat_o <= {24'h00_0000, ctl0_q};
               `LM_ADDR_CTL_ONE: dat_o <= {30'h0000_0000, ctl1_q};
               `LM_ADDR_ERR_SEL: dat_o <= {30'h0000_0000, err_type_q};
               `LM_ADDR_STATUS: dat_o <= {30'h0000_0000, pattern_sync_status_o, alarm_indication_status_o};
               `LM_ADDR_EVENT: dat_o <= {31'h0000_0000, event_flag_q};
               `LM_ADDR_EDGE: dat_o <= {31'h0000_0000, edge_select_q};
               `LM_ADDR_MASK: dat_o <= {31'h0000_0000, mask_q};
               `LM_ADDR_ERRCNT: dat_o <= {16'h0000, err_cnt_q};
               `LM_ADDR_CODE: dat_o <= {22'h00_0000, code_q};
               default: dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ---------------- transmit side ----------------
   logic tx_clk_q; // previous transmit clock level
   logic mclk_q; // previous master clock level
   logic tx_tick; // one cycle per transmit bit
   logic pclk_now; // selected bit clock level
   assign pclk_now = ctrl.pattern_clock_select ? master_clock_i : transmit_clock_i;
   assign tx_tick = ctrl.pattern_clock_select ? (master_clock_i & ~mclk_q) : (transmit_clock_i & ~tx_clk_q);

   // edge history of both bit clocks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_clk_q <= 1'b0;
         mclk_q <= 1'b0;
      end else begin
         tx_clk_q <= transmit_clock_i;
         mclk_q <= master_clock_i;
      end
   end

   // generator register; e1 uses the low 15 stages only
   logic [19:0] gen_q;
   logic gen_fb;
   logic gen_bit;
   assign gen_fb = ctrl.t1_mode ? (gen_q[19] ^ gen_q[16]) : (gen_q[14] ^ gen_q[13]);
   // zero limiting forces a one after too long a run of zero stages
   assign gen_bit = (ctrl.t1_mode && gen_q[`LM_ZLIM_BITS-1:0] == '0) ? 1'b1 : gen_fb;

   // generator advances once per bit, msb first, while the sequence is chosen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gen_q <= 20'hF_FFFF;
      end else if (tx_tick && ctrl.pattern_select == `LM_SEL_PRBS) begin
         gen_q <= {gen_q[18:0], gen_fb};
      end
   end

   // loopback code walks round its programmed length of 5 to 8 bits
   logic [2:0] code_pos_q;
   logic [2:0] code_last;
   assign code_last = 3'h4 + {1'b0, code_q[9:8]};
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         code_pos_q <= 3'h0;
      end else if (ctrl.pattern_select != `LM_SEL_CODE) begin
         code_pos_q <= 3'h0;
      end else if (tx_tick) begin
         code_pos_q <= (code_pos_q == code_last) ? 3'h0 : code_pos_q + 3'h1;
      end
   end

   // transmit content choice
   logic tx_bit;
   always_comb begin
      case (ctrl.pattern_select)
         `LM_SEL_NORMAL: tx_bit = ctrl.pattern_clock_select ? 1'b0 : transmit_data_i;
         `LM_SEL_ONES: tx_bit = 1'b1;
         `LM_SEL_PRBS: tx_bit = gen_bit ^ ctrl.pattern_invert;
         `LM_SEL_CODE: tx_bit = code_q[3'h7 - code_pos_q];
         default: tx_bit = transmit_data_i;
      endcase
   end

   // line outputs keep running during either loop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_transmit_clock_o <= 1'b0;
         line_transmit_pair_o <= 1'b0;
      end else begin
         line_transmit_clock_o <= pclk_now;
         if (tx_tick) begin
            line_transmit_pair_o <= tx_bit;
         end
      end
   end

   // ---------------- receive side ----------------
   logic rclk_q; // previous line receive clock
   logic loop_on;
   logic rx_tick;
   logic rx_bit;
   assign loop_on = ctrl.analog_loop_enable | ctrl.digital_loop_enable;
   // in loopback the transmitted bit and its strobe feed the receive path
   assign rx_tick = loop_on ? tx_tick : (line_receive_clock_i & ~rclk_q);
   assign rx_bit = loop_on ? tx_bit : line_receive_data_i;

   // receive outputs; data sits on the positive rail, negative rail idle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rclk_q <= 1'b0;
         receive_clock_o <= 1'b0;
         receive_dual_rail_data_o <= 2'h0;
      end else begin
         rclk_q <= line_receive_clock_i;
         receive_clock_o <= loop_on ? pclk_now : line_receive_clock_i;
         if (rx_tick) begin
            receive_dual_rail_data_o <= {rx_bit, 1'b0};
         end
      end
   end

   // ---------------- alarm indication detect ----------------
   logic [12:0] blk_cnt_q; // bits seen in the current block
   logic [3:0] zero_cnt_q; // zeros seen, saturating at nine
   logic prev_low_q; // previous e1 block was short of zeros
   logic blk_end;
   logic blk_low;
   logic [12:0] blk_len;
   logic [3:0] zero_cnt_d;
   assign blk_len = ctrl.t1_mode ? `LM_T1_BLOCK : `LM_E1_BLOCK;
   assign blk_end = rx_tick && (blk_cnt_q == blk_len);
   assign zero_cnt_d = (!rx_bit && zero_cnt_q != `LM_T1_ZEROS) ? zero_cnt_q + 4'h1 : zero_cnt_q;
   assign blk_low = zero_cnt_d < (ctrl.t1_mode ? `LM_T1_ZEROS : `LM_E1_ZEROS);

   // block counting; idle and cleared while clock recovery is off
   always_ff @(posedge clk_i) begin
      if (rst_i || !ctrl.cdr_enable) begin
         blk_cnt_q <= 13'h0000;
         zero_cnt_q <= 4'h0;
         prev_low_q <= 1'b0;
      end else if (rx_tick) begin
         blk_cnt_q <= blk_end ? 13'h0000 : blk_cnt_q + 13'h1;
         zero_cnt_q <= blk_end ? 4'h0 : zero_cnt_d;
         prev_low_q <= blk_end ? blk_low : prev_low_q;
      end
   end

   // declare and clear decisions at each block boundary
   always_ff @(posedge clk_i) begin
      if (rst_i || !ctrl.cdr_enable) begin
         alarm_indication_status_o <= 1'b0;
      end else if (blk_end) begin
         if (ctrl.t1_mode) begin
            alarm_indication_status_o <= blk_low;
         end else if (blk_low && prev_low_q) begin
            alarm_indication_status_o <= 1'b1;
         end else if (!blk_low && (ctrl.loss_criteria_select || !prev_low_q)) begin
            alarm_indication_status_o <= 1'b0;
         end
      end
   end

   // ---------------- pattern monitor ----------------
   det_state_t det_q;
   logic [19:0] ref_q; // reference sequence register
   logic ref_fb;
   logic rx_plain; // received bit with inversion removed
   logic rx_err;
   logic [5:0] win_cnt_q; // position in the 64-bit window
   logic [6:0] win_err_q; // errors in the window so far
   logic [6:0] win_err_d;
   assign ref_fb = ctrl.t1_mode ? (ref_q[19] ^ ref_q[16]) : (ref_q[14] ^ ref_q[13]);
   assign rx_plain = rx_bit ^ ctrl.pattern_invert;
   // a forced one from zero limiting is expected, not an error
   assign rx_err = rx_plain != ((ctrl.t1_mode && ref_q[`LM_ZLIM_BITS-1:0] == '0) ? 1'b1 : ref_fb);
   assign win_err_d = win_err_q + {6'h00, rx_err};

   // hunting seeds the reference from the line; locked it runs free
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_q <= 20'h0_0000;
      end else if (rx_tick) begin
         ref_q <= {ref_q[18:0], (det_q == DET_LOCK) ? ref_fb : rx_plain};
      end
   end

   // hopping windows: the verdict is taken once per 64 bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         det_q <= DET_HUNT;
         win_cnt_q <= 6'h00;
         win_err_q <= 7'h00;
      end else if (rx_tick) begin
         win_cnt_q <= win_cnt_q + 6'h01;
         win_err_q <= (win_cnt_q == `LM_WIN_BITS) ? 7'h00 : win_err_d;
         if (win_cnt_q == `LM_WIN_BITS) begin
            case (det_q)
               DET_HUNT: det_q <= (win_err_d <= `LM_MAX_ERRS) ? DET_LOCK : DET_HUNT;
               DET_LOCK: det_q <= (win_err_d > `LM_MAX_ERRS) ? DET_HUNT : DET_LOCK;
               default: det_q <= DET_HUNT;
            endcase
         end
      end
   end

   // sync status output and its previous value for edge capture
   logic sync_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pattern_sync_status_o <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         pattern_sync_status_o <= (det_q == DET_LOCK);
         sync_q <= pattern_sync_status_o;
      end
   end

   // event flag: capture beats the clear-on-read in the same cycle
   logic sync_event;
   assign sync_event = edge_select_q ? (pattern_sync_status_o != sync_q) : (pattern_sync_status_o & ~sync_q);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         event_flag_q <= 1'b0;
      end else if (sync_event) begin
         event_flag_q <= 1'b1;
      end else if (rd_en && adr_i == `LM_ADDR_EVENT) begin
         event_flag_q <= 1'b0;
      end
   end

   // interrupt pin follows flag and mask one cycle later
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         interrupt_o <= 1'b0;
      end else begin
         interrupt_o <= event_flag_q & mask_q;
      end
   end

   // error counter: locked mismatches, saturating; a write clears it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err_cnt_q <= 16'h0000;
      end else if (rx_tick && det_q == DET_LOCK && rx_err && err_type_q == `LM_ERR_PATTERN) begin
         err_cnt_q <= (err_cnt_q == 16'hFFFF) ? err_cnt_q : err_cnt_q + 16'h0001;
      end else if (wr_en && adr_i == `LM_ADDR_ERRCNT) begin
         err_cnt_q <= 16'h0000;
      end
   end

endmodule
`default_nettype wire

// ==== line_maintenance_chk.sv ====
// Purpose: port-level checker for line_maintenance
// Assumes: bit clocks stay at each level for at least one clk_i cycle
// Notes: status spacing is checked by gap counters, not long repetitions
`include "lm_cfg.svh"
`default_nettype none
module line_maintenance_chk (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic [31:0] dat_o,
   // pins and streams
   input wire logic hw_mode_i,
   input wire logic [1:0] loop_select_pins_i,
   input wire logic [1:0] pattern_select_pins_i,
   input wire logic transmit_data_i,
   input wire logic line_transmit_clock_o,
   input wire logic line_transmit_pair_o,
   input wire logic receive_clock_o,
   input wire logic alarm_indication_status_o,
   input wire logic pattern_sync_status_o,
   input wire logic interrupt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [7:0] sync_gap_q; // cycles since sync last moved
   logic [11:0] alarm_gap_q; // cycles since alarm last moved
   // gap counters saturate so a long quiet spell never wraps into a false failure
   always_ff @(posedge clk_i) begin
      if (rst_i) sync_gap_q <= 8'h00;
      else if ($changed(pattern_sync_status_o)) sync_gap_q <= 8'h00;
      else if (sync_gap_q != 8'hFF) sync_gap_q <= sync_gap_q + 8'h01;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) alarm_gap_q <= 12'h000;
      else if ($changed(alarm_indication_status_o)) alarm_gap_q <= 12'h000;
      else if (alarm_gap_q != 12'hFFF) alarm_gap_q <= alarm_gap_q + 12'h001;
   end
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack after request");
   a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
   a_upper_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0000) else $error("upper read bits set");
   a_reset_quiet: assert property ($fell(rst_i) |-> !(ack_o || interrupt_o || pattern_sync_status_o))
      else $error("output high after reset");
   a_hw_ones: assert property ((hw_mode_i && pattern_select_pins_i == `LM_SEL_ONES) [*4] ##0
      $rose(line_transmit_clock_o) |-> line_transmit_pair_o) else $error("ones pattern wrong");
   a_hw_normal: assert property ((hw_mode_i && pattern_select_pins_i == `LM_SEL_NORMAL &&
      $stable(transmit_data_i)) [*4] ##0 $rose(line_transmit_clock_o) |-> line_transmit_pair_o == transmit_data_i)
      else $error("normal data not passed");
   a_loop_clock: assert property ((hw_mode_i && loop_select_pins_i == `LM_LOOP_DIGITAL) [*3] |->
      receive_clock_o == line_transmit_clock_o) else $error("loop clock not routed");
   a_sync_spacing: assert property ($changed(pattern_sync_status_o) |-> sync_gap_q >= 8'd120)
      else $error("sync moved inside a window");
   a_alarm_spacing: assert property ($rose(alarm_indication_status_o) |-> alarm_gap_q >= 12'd1000)
      else $error("alarm declared too soon");
   c_sync: cover property ($rose(pattern_sync_status_o));
   c_alarm: cover property ($rose(alarm_indication_status_o));
   c_irq: cover property ($rose(interrupt_o));
endmodule
bind line_maintenance line_maintenance_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .ack_o(ack_o), .dat_o(dat_o), .hw_mode_i(hw_mode_i), .loop_select_pins_i(loop_select_pins_i),
   .pattern_select_pins_i(pattern_select_pins_i), .transmit_data_i(transmit_data_i),
   .line_transmit_clock_o(line_transmit_clock_o), .line_transmit_pair_o(line_transmit_pair_o),
   .receive_clock_o(receive_clock_o), .alarm_indication_status_o(alarm_indication_status_o),
   .pattern_sync_status_o(pattern_sync_status_o), .interrupt_o(interrupt_o));
`default_nettype wire

// ==== line_far_end.sv ====
// Purpose: model of the framer clocks and the remote line stream
// Assumes: system and line clocks run free, as they do on a live span
// Notes: receive data moves on the falling line clock, far from its sampling rise
`default_nettype none
module line_far_end (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // one zero every this many bits, 0 sends all ones
   input wire logic [7:0] zero_gap_i,
   // clocks and line stream
   output logic transmit_clock_o,
   output logic master_clock_o,
   output logic rx_clock_o,
   output logic rx_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int tc, mc, rc, nb; // phase counters and received bit count
   // transmit period 4, master 6, line 8 cycles, so each clock is told apart
   always_ff @(posedge clk_i) begin
      tc <= (tc >= 3) ? 0 : tc + 1;
      mc <= (mc >= 5) ? 0 : mc + 1;
      rc <= (rc >= 7) ? 0 : rc + 1;
      transmit_clock_o <= tc < 2;
      master_clock_o <= mc < 3;
      rx_clock_o <= rc < 4;
      if (rst_i) begin
         nb <= 0;
         rx_data_o <= 1'b1;
      end else if (rc == 4) begin
         nb <= nb + 1;
         rx_data_o <= !(zero_gap_i != 8'h00 && nb % zero_gap_i == 0);
      end
   end
endmodule
`default_nettype wire

// ==== line_maintenance_tb.sv ====
// Purpose: self-checking bench for line_maintenance
// Assumes: far-end model makes every bit clock
// Notes: loops carry the internal pattern, so the detector is fed locally
`include "lm_cfg.svh"
`default_nettype none
module line_maintenance_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] adr_ctl = 8'h00, adr_loop = 8'h04, adr_err = 8'h08;
   localparam logic [7:0] adr_flag = 8'h10, adr_edge = 8'h14, adr_mask = 8'h18;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, hw_mode_i = 0, transmit_data_i = 0;
   logic [7:0] adr_i = 8'h00, gap = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic [1:0] loop_pins = 2'h0, pp = 2'h0;
   logic ack_o, tck, mck, rck, rxd, ltc, ltp, rco, ais, syn, interrupt_o;
   logic [1:0] rdd;
   logic [39:0] s;
   int n_errors = 0, samples_checked = 0, cyc_n = 0, n;
   line_far_end u_far (.clk_i(clk_i), .rst_i(rst_i), .zero_gap_i(gap), .transmit_clock_o(tck),
      .master_clock_o(mck), .rx_clock_o(rck), .rx_data_o(rxd));
   line_maintenance u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .hw_mode_i(hw_mode_i),
      .loop_select_pins_i(loop_pins), .pattern_select_pins_i(pp), .transmit_clock_i(tck), .master_clock_i(mck),
      .transmit_data_i(transmit_data_i), .line_receive_clock_i(rck), .line_receive_data_i(rxd),
      .line_transmit_clock_o(ltc), .line_transmit_pair_o(ltp), .receive_clock_o(rco),
      .receive_dual_rail_data_o(rdd), .alarm_indication_status_o(ais), .pattern_sync_status_o(syn),
      .interrupt_o(interrupt_o));
   // 40 ns clock
   initial begin
      forever #20 clk_i = !clk_i;
   end
   // hang guard, well above the longest alarm waits
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 90000) begin
         n_errors++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   // classic single cycle; the request stands until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'h3;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 0; stb_i <= 0; we_i <= 0;
      @(posedge clk_i);
   endtask
   // cycles between two rises of the transmit clock copy or the receive clock
   task automatic period(input logic rx);
      logic p, c;
      int k;
      k = 0; n = 0; p = 1;
      while (k < 2 && n < 200) begin
         @(negedge clk_i);
         c = rx ? rco : ltc;
         if (k == 1) n++;
         if (c === 1'b1 && p === 1'b0) k++;
         p = c;
      end
   endtask
   // cnt transmitted bits into s, each taken when the transmit clock copy rises
   task automatic get_bits(input int cnt);
      logic p;
      int t;
      for (int i = 0; i < cnt; i++) begin
         p = 1; t = 0;
         do begin
            @(negedge clk_i);
            t++;
            if (ltc === 1'b1 && p === 1'b0) t = 1000;
            p = ltc;
         end while (t < 100);
         s[i] = ltp;
      end
   endtask
   // either tap order of the shift register is accepted
   function automatic logic rec_ok(input logic inv);
      logic a, b;
      a = 1; b = 1;
      for (int i = 15; i < 40; i++) begin
         if (s[i] !== (s[i-14] ^ s[i-15] ^ inv)) a = 0;
         if (s[i] !== (s[i-1] ^ s[i-15] ^ inv)) b = 0;
      end
      return a | b;
   endfunction
   task automatic wait_st(input logic sy, input logic v, input int lim);
      int t;
      t = 0;
      while ((sy ? syn : ais) !== v && t < lim) begin
         @(negedge clk_i);
         t++;
      end
      chk(sy ? syn : ais, v);
   endtask
   task automatic t_reset();
      wb(0, adr_ctl, 0); chk(q, 32'h40);
      wb(0, `LM_ADDR_CODE, 0); chk(q, 32'h301);
      wb(1, 8'h24, 32'hFF); wb(0, 8'h24, 0); chk(q, 0);
      $display("test reset done");
   endtask
   task automatic t_tx();
      logic [7:0] c [4] = '{8'h40, 8'h40, 8'h44, 8'h42};
      logic [3:0] d = 4'b1001, e = 4'b0101;
      for (int i = 0; i < 4; i++) begin
         wb(1, adr_ctl, c[i]);
         transmit_data_i <= d[i];
         get_bits(4); chk(s[3], e[i]);
      end
      period(0); chk(n, 6);
      $display("test transmit done");
   endtask
   task automatic t_hw();
      @(posedge clk_i);
      hw_mode_i <= 1; pp <= `LM_SEL_ONES; transmit_data_i <= 0;
      get_bits(4); chk(s[3], 1);
      @(posedge clk_i);
      pp <= `LM_SEL_NORMAL; transmit_data_i <= 1;
      get_bits(4); chk(s[3], 1);
      @(posedge clk_i);
      loop_pins <= `LM_LOOP_ANALOG;
      period(1); chk(n, 4);
      @(posedge clk_i);
      loop_pins <= `LM_LOOP_DIGITAL; pp <= `LM_SEL_PRBS;
      period(1); chk(n, 4);
      get_bits(40); chk(rec_ok(0), 1);
      @(posedge clk_i);
      pp <= `LM_SEL_CODE; loop_pins <= 2'h0;
      get_bits(24); chk($countones(s[23:8]), 2); chk(s[23:8] & (s[23:8] >> 8), s[23:16] & s[15:8]);
      @(posedge clk_i);
      hw_mode_i <= 0; pp <= `LM_SEL_NORMAL;
      $display("test hardware pins done");
   endtask
   task automatic t_prbs();
      wb(1, adr_err, `LM_ERR_PATTERN); wb(1, adr_edge, 0); wb(1, adr_mask, 1);
      wb(1, adr_loop, 2); wb(1, adr_ctl, 8'h48);
      get_bits(40); chk(rec_ok(0), 1);
      wait_st(1, 1, 3000);
      repeat (2) @(negedge clk_i); chk(interrupt_o, 1);
      wb(0, adr_flag, 0); chk(q, 1);
      wb(1, `LM_ADDR_ERRCNT, 0); get_bits(100); wb(0, `LM_ADDR_ERRCNT, 0); chk(q, 0);
      wb(1, adr_ctl, 8'h58);
      get_bits(40); chk(rec_ok(1), 1);
      wb(1, adr_ctl, 8'h44); wait_st(1, 0, 3000);
      wb(0, `LM_ADDR_ERRCNT, 0); chk(q != 0, 1);
      wb(0, adr_flag, 0); chk(q, 0);
      wb(1, adr_edge, 1); wb(1, adr_mask, 0); wb(1, adr_loop, 1); wb(1, adr_ctl, 8'h48);
      wait_st(1, 1, 3000);
      repeat (2) @(negedge clk_i); chk(interrupt_o, 0);
      wb(0, adr_flag, 0); chk(q, 1);
      wb(1, adr_ctl, 8'h44); wait_st(1, 0, 3000);
      wb(0, adr_flag, 0); chk(q, 1);
      wb(1, adr_loop, 0);
      $display("test pattern monitor done");
   endtask
   task automatic t_alarm();
      gap <= 8'h00;
      wb(1, adr_ctl, 8'h40); wait_st(0, 1, 13000);
      gap <= 8'd100;
      wb(1, adr_ctl, 8'h41); wait_st(0, 0, 8800);
      gap <= 8'h00;
      wait_st(0, 1, 13000);
      wb(1, adr_ctl, 8'h01); wait_st(0, 0, 10);
      $display("test alarm done");
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      t_reset();
      t_tx();
      t_hw();
      t_prbs();
      t_alarm();
      complete_run();
   end
endmodule
`default_nettype wire
